// >>> core/eprf_unit.sv
// Function
// RULE1 - rank exceptions groups 0..4, process simultaneous ones highest first
// RULE2 - reset aborts all processing and discards old context unsaved
// RULE3 - address error outranks bus error; both save internal context
// RULE4 - group 2 processed as part of the raising instruction
// RULE5 - group 3 starts before the offending instruction executes
// RULE6 - trace, breakpoint, interrupt taken only at completion points
// RULE7 - after one exception, process next pending before handler fetch
// RULE8 - reset clears every other pending exception
// RULE9 - higher fault during lower processing is processed first
// RULE10 - reset from external pin or internal module reset
// RULE11 - reset clears trace bits, sets supervisor, mask 7, base zero
// RULE12 - reset loads stack pointer, then program counter, then fetches
// RULE13 - reset pushes no program counter or status register
// RULE14 - fault during reset processing halts and asserts halt
// RULE15 - reset instruction drives reset output, touches no register
// RULE16 - bus fault from pin, on-chip module or watchdog
// RULE17 - faulted prefetch raises only if used, dropped on flush
// RULE18 - data fault immediate, released write held to boundary/operand access
// RULE19 - restore EA registers, push status word, address, vector, pc, sr
// RULE20 - bus fault during fault/reset processing or return stack read halts
// RULE21 - odd word or instruction access raises address error like bus fault
// RULE22 - odd branch faults only when taken; frame holds target and branch
// RULE23 - address error during fault or reset processing halts
// RULE24 - vector address is base plus four times vector number
// RULE25 - hold pending flag per source until its processing starts
`timescale 1ns/1ps
`default_nettype none

module eprf_unit
  import eprf_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // reset sources and reset output
  input  wire logic         resetPin,
  input  wire logic         resetModule,
  input  wire logic         resetInsn,
  output logic              resetOut,
  // fault sources from the core pipeline
  input  wire logic         busFaultPin,
  input  wire logic         busFaultModule,
  input  wire logic         busFaultWatchdog,
  input  wire logic         accOdd,
  input  wire eprf_access_t accInfo,
  input  wire logic         prefetchUsed,
  input  wire logic         prefetchFlush,
  input  wire logic         insnBoundary,
  input  wire logic         operandAccess,
  input  wire logic         rteStackRead,
  input  wire logic         branchOdd,
  input  wire logic [31:0]  branchTarget,
  input  wire logic [31:0]  branchPc,
  input  wire logic [31:0]  curPc,
  // other exception requests
  input  wire eprf_req_t    group2Req,
  input  wire eprf_req_t    group3Req,
  input  wire logic         traceReq,
  input  wire logic         hwBkptReq,
  input  wire eprf_req_t    irqReq,
  input  wire logic [2:0]   irqLevel,
  // core control
  output logic              stallExec,
  output logic              restoreEa,
  output logic              fetchGo,
  output logic [31:0]       pcOut,
  output logic [31:0]       spOut,
  output eprf_sr_t          srOut,
  output logic              halted,
  // memory port for stacking and vector reads
  output logic              memReq,
  output logic              memWrite,
  output logic [31:0]       memAddr,
  output logic [31:0]       memWdata,
  input  wire logic [31:0]  memRdata,
  input  wire logic         memAck,
  input  wire logic         memErr,
  // register port
  input  wire logic [3:0]   regAddr,
  input  wire logic [31:0]  regWdata,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic [31:0]       regRdata
);

  // ------
  // helpers
  // ------
  typedef enum logic [2:0] {
    S_IDLE, S_RST_ISP, S_RST_PC, S_ENTER, S_RESTORE, S_PUSH, S_VEC, S_HALT
  } eprf_state_t;

  // first pending kind, group 4 only where allowed
  function automatic logic [2:0] pickKind(input logic [KINDS-1:0] p, input logic g4ok);
    logic [2:0] k;
    k = K_NONE;
    for (int i = KINDS - 1; i >= 0; i--) begin
      if (p[i] && (g4ok || 3'(i) < K_FIRST_G4)) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  // base plus vector times four
  function automatic logic [31:0] vecAddr(input logic [31:0] base, input logic [7:0] vec);
    return base + (32'(vec) << VEC_SHIFT); // [RULE24]
  endfunction

  // ------
  // state
  // ------
  eprf_state_t     state_q, state_d;
  logic [KINDS-1:0] pend_q, pend_d;
  logic [2:0]      cur_q, cur_d, idx_q, idx_d;
  logic [7:0]      curVec_q, curVec_d, g2Vec_q, g3Vec_q, irqVec_q;
  logic [31:0]     pc_q, pc_d, sp_q, sp_d, vtb_q;
  eprf_sr_t        sr_q, sr_d, srCopy_q, srCopy_d;
  logic            halt_q, halt_d, fetch_d, restore_d;
  eprf_access_t    fInfo_q, prefInfo_q, relInfo_q;
  logic [31:0]     fPc_q, fIptr_q;
  logic            fIsAddr_q, prefHeld_q, prefAddr_q, relHeld_q, relAddr_q;
  logic [KINDS-1:0] rearm;
  logic [15:0]     rstCnt_q;
  logic [31:0]     regRdata_q;

  // ------
  // decode of events
  // ------
  wire logic rstExc    = resetPin | resetModule; // [RULE10]
  wire logic busFault  = busFaultPin | busFaultModule | busFaultWatchdog; // [RULE16]
  wire logic faultEv   = (busFault | accOdd) & (state_q == S_IDLE);
  wire logic isAddrEv  = accOdd; // odd access outranks a bus fault on the same cycle [RULE3]
  wire logic faultNow  = faultEv & ~accInfo.prefetch & ~accInfo.released; // [RULE18]
  wire logic rteDouble = faultEv & rteStackRead; // [RULE20]
  wire logic relFire   = relHeld_q & (insnBoundary | operandAccess); // [RULE18]
  wire logic prefFire  = prefHeld_q & prefetchUsed; // [RULE17]
  wire logic inFault   = (cur_q == K_ADDR) || (cur_q == K_BUS);
  wire logic inReset   = (state_q == S_RST_ISP) || (state_q == S_RST_PC);
  wire logic spOdd     = sp_q[0];
  wire logic pushOddEv = (state_q == S_PUSH) & spOdd; // odd stack is an address error [RULE21]
  wire logic memFault  = (memAck & memErr) | pushOddEv;
  wire logic [2:0] pickIdle = pickKind(pend_q, insnBoundary); // [RULE6]
  wire logic [2:0] pickEnd  = pickKind(pend_q, 1'b1); // exception end is a completion point [RULE6]
  wire logic startIdle = (state_q == S_IDLE) & (pickIdle != K_NONE) & ~rteDouble;
  wire logic [31:0] vecRdAddr = vecAddr(vtb_q, curVec_q);
  wire logic [31:0] pushAddr  = sp_q - WORD_BYTES;
  wire logic [2:0]  firstIdx  = inFault ? FRAME_SSW : FRAME_VECW;

  // pending sets from sources; one fault slot, address error wins
  wire logic [KINDS-1:0] pendSet = {
    irqReq.valid, hwBkptReq, traceReq, group3Req.valid, group2Req.valid,
    (faultNow & ~isAddrEv) | (relFire & ~relAddr_q) | (prefFire & ~prefAddr_q),
    (faultNow & isAddrEv) | (relFire & relAddr_q) | (prefFire & prefAddr_q) | branchOdd
  };

  // stacked word selection
  eprf_ssw_t fault_status_word;
  assign fault_status_word = '{rsv: '0, cyc: fInfo_q.cyc, wr: fInfo_q.wr, size: fInfo_q.size,
                 fc: fInfo_q.fc};
  wire logic [11:0] vecOff = 12'(32'(curVec_q) << VEC_SHIFT);
  wire logic [31:0] vecWord = {16'h0000, inFault ? FMT_FAULT : FMT_NORMAL, vecOff};
  wire logic [31:0] frameWord =
      (idx_q == FRAME_SSW)   ? {16'h0000, fault_status_word} :
      (idx_q == FRAME_FADDR) ? fInfo_q.addr :
      (idx_q == FRAME_IPTR)  ? fIptr_q :
      (idx_q == FRAME_VECW)  ? vecWord :
      (idx_q == FRAME_PC)    ? (inFault ? fPc_q : pc_q) :
                               {16'h0000, srCopy_q}; // [RULE19]

  // ------
  // memory port and core handshakes
  // ------
  assign memReq    = inReset | (state_q == S_VEC) | ((state_q == S_PUSH) & ~spOdd);
  assign memWrite  = (state_q == S_PUSH);
  assign memAddr   = (state_q == S_RST_ISP) ? RST_ISP_ADDR :
                     (state_q == S_RST_PC)  ? RST_PC_ADDR :
                     (state_q == S_VEC)     ? vecRdAddr : pushAddr;
  assign memWdata  = frameWord;
  // decode-time stall keeps an illegal opcode from executing [RULE5]
  assign stallExec = (state_q != S_IDLE) | startIdle | group3Req.valid;

  // ------
  // sequencer next state
  // ------
  always_comb begin
    state_d   = state_q;
    cur_d     = cur_q;
    curVec_d  = curVec_q;
    idx_d     = idx_q;
    pc_d      = pc_q;
    sp_d      = sp_q;
    sr_d      = sr_q;
    srCopy_d  = srCopy_q;
    halt_d    = halt_q;
    fetch_d   = 1'b0;
    restore_d = 1'b0;
    rearm     = '0;
    unique case (state_q)
      S_IDLE: begin
        if (rteDouble) begin
          state_d = S_HALT; // [RULE20]
          halt_d  = 1'b1;
        end else if (startIdle) begin
          state_d = S_ENTER; // highest pending first [RULE1]
          cur_d   = pickIdle;
        end
      end
      S_RST_ISP: begin
        if (memAck && memErr) begin
          state_d = S_HALT; // double fault [RULE14]
          halt_d  = 1'b1;
        end else if (memAck) begin
          sp_d    = memRdata; // [RULE12]
          state_d = S_RST_PC;
        end
      end
      S_RST_PC: begin
        if ((memAck && memErr) || (memAck && memRdata[0])) begin
          state_d = S_HALT; // bus or address error while resetting [RULE14] [RULE23]
          halt_d  = 1'b1;
        end else if (memAck) begin
          pc_d    = memRdata; // [RULE12]
          fetch_d = 1'b1;
          state_d = S_IDLE; // nothing was stacked [RULE13]
        end
      end
      S_ENTER: begin
        srCopy_d      = sr_q;
        sr_d.supervisor = 1'b1;
        sr_d.traceHi  = 1'b0;
        sr_d.traceLo  = 1'b0;
        if (cur_q == K_IRQ) begin
          sr_d.ipm = irqLevel;
        end
        curVec_d = (cur_q == K_ADDR)  ? VEC_ADDR :
                   (cur_q == K_BUS)   ? VEC_BUS :
                   (cur_q == K_G2)    ? g2Vec_q :
                   (cur_q == K_G3)    ? g3Vec_q :
                   (cur_q == K_TRACE) ? VEC_TRACE :
                   (cur_q == K_BKPT)  ? VEC_HWBKPT : irqVec_q;
        idx_d   = firstIdx;
        state_d = inFault ? S_RESTORE : S_PUSH; // [RULE3]
      end
      S_RESTORE: begin
        restore_d = 1'b1; // undo EA side effects before stacking [RULE19]
        state_d   = S_PUSH;
      end
      S_PUSH: begin
        if (memFault) begin
          if (inFault) begin
            state_d = S_HALT; // [RULE20] [RULE23]
            halt_d  = 1'b1;
          end else begin
            rearm[cur_q] = 1'b1; // resumed after the fault is processed [RULE9]
            state_d      = S_IDLE;
          end
        end else if (memAck) begin
          sp_d = pushAddr;
          if (idx_q == FRAME_SR) begin
            state_d = S_VEC;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      S_VEC: begin
        if (memAck && memErr) begin
          if (inFault) begin
            state_d = S_HALT; // [RULE20]
            halt_d  = 1'b1;
          end else begin
            rearm[cur_q] = 1'b1; // [RULE9]
            state_d      = S_IDLE;
          end
        end else if (memAck) begin
          pc_d = memRdata; // handler becomes the next frame's return address
          if (pickEnd != K_NONE) begin
            cur_d   = pickEnd; // chain before any handler runs [RULE7]
            state_d = S_ENTER;
          end else begin
            fetch_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_HALT: begin
        halt_d = 1'b1; // only a reset leaves this state
      end
    endcase
  end

  // pending bookkeeping; sets win over the start that clears [RULE25]
  always_comb begin
    pend_d = pend_q;
    if (state_q == S_ENTER) begin
      pend_d[cur_q] = 1'b0;
    end
    pend_d = pend_d | pendSet | rearm;
    if ((state_q == S_PUSH || state_q == S_VEC) && memFault && !inFault) begin
      pend_d[K_BUS] = pend_d[K_BUS] | ~pushOddEv;
      pend_d[K_ADDR] = pend_d[K_ADDR] | pushOddEv;
    end
  end

  // ------
  // sequencer registers
  // ------
  always_ff @(posedge core_clk) begin
    if (srst || (ce && rstExc)) begin
      state_q  <= S_RST_ISP; // abort, nothing saved [RULE2]
      pend_q   <= '0; // [RULE8]
      cur_q    <= K_NONE;
      curVec_q <= '0;
      idx_q    <= '0;
      pc_q     <= '0;
      sp_q     <= '0;
      sr_q     <= '{traceHi: 1'b0, traceLo: 1'b0, supervisor: 1'b1, rsv: '0,
                    ipm: IPM_RESET, ccr: '0}; // [RULE11]
      srCopy_q <= '0;
      halt_q   <= 1'b0;
      fetchGo  <= 1'b0;
      restoreEa <= 1'b0;
    end else if (ce) begin
      state_q  <= state_d;
      pend_q   <= pend_d;
      cur_q    <= cur_d;
      curVec_q <= curVec_d;
      idx_q    <= idx_d;
      pc_q     <= pc_d;
      sp_q     <= sp_d;
      sr_q     <= sr_d;
      srCopy_q <= srCopy_d;
      halt_q   <= halt_d;
      fetchGo  <= fetch_d;
      restoreEa <= restore_d;
    end
  end

  // ------
  // fault capture and deferred faults
  // ------
  // one shared fault slot: the most recent capture is what gets stacked
  always_ff @(posedge core_clk) begin
    if (srst || (ce && rstExc)) begin
      fInfo_q    <= '0;
      fPc_q      <= '0;
      fIptr_q    <= '0;
      fIsAddr_q  <= 1'b0;
      prefHeld_q <= 1'b0;
      prefAddr_q <= 1'b0;
      prefInfo_q <= '0;
      relHeld_q  <= 1'b0;
      relAddr_q  <= 1'b0;
      relInfo_q  <= '0;
      g2Vec_q    <= '0;
      g3Vec_q    <= '0;
      irqVec_q   <= '0;
    end else if (ce) begin
      if (branchOdd) begin
        fInfo_q      <= accInfo;
        fInfo_q.addr <= branchTarget; // [RULE22]
        fPc_q        <= branchTarget;
        fIptr_q      <= branchPc;
        fIsAddr_q    <= 1'b1;
      end else if (faultNow) begin
        fInfo_q   <= accInfo; // [RULE21]
        fPc_q     <= curPc;
        fIptr_q   <= curPc;
        fIsAddr_q <= isAddrEv;
      end else if (relFire) begin
        fInfo_q   <= relInfo_q;
        fPc_q     <= curPc;
        fIptr_q   <= curPc;
        fIsAddr_q <= relAddr_q;
      end else if (prefFire) begin
        fInfo_q   <= prefInfo_q;
        fPc_q     <= curPc;
        fIptr_q   <= curPc;
        fIsAddr_q <= prefAddr_q;
      end
      if (faultEv && accInfo.prefetch) begin
        prefHeld_q <= 1'b1; // [RULE17]
        prefAddr_q <= isAddrEv;
        prefInfo_q <= accInfo;
      end else if (prefetchUsed || prefetchFlush) begin
        prefHeld_q <= 1'b0; // flushed word never faults [RULE17]
      end
      if (faultEv && accInfo.released && !accInfo.prefetch) begin
        relHeld_q <= 1'b1; // [RULE18]
        relAddr_q <= isAddrEv;
        relInfo_q <= accInfo;
      end else if (relFire) begin
        relHeld_q <= 1'b0;
      end
      if (group2Req.valid) begin
        g2Vec_q <= group2Req.vector; // [RULE4]
      end
      if (group3Req.valid) begin
        g3Vec_q <= group3Req.vector; // [RULE5]
      end
      if (irqReq.valid) begin
        irqVec_q <= irqReq.vector;
      end
    end
  end

  // ------
  // reset instruction output
  // ------
  // external pulse only; no processor register is touched [RULE15]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rstCnt_q <= '0;
    end else if (ce) begin
      if (resetInsn && !halt_q) begin
        rstCnt_q <= RST_OUT_CYCLES; // [RULE15]
      end else if (rstCnt_q != '0) begin
        rstCnt_q <= rstCnt_q - 16'h0001;
      end
    end
  end
  assign resetOut = (rstCnt_q != '0);

  // ------
  // register port
  // ------
  wire logic [31:0] statusWord = {16'h0000, 4'h0, fIsAddr_q, halt_q,
                                  prefHeld_q, relHeld_q, 1'b0, pend_q};
  wire logic [31:0] rdMux = (regAddr == REG_VTB)    ? vtb_q :
                            (regAddr == REG_STATUS) ? statusWord :
                            (regAddr == REG_SR)     ? {16'h0000, sr_q} : 32'h0000_0000;

  // base register cleared by either reset [RULE11]
  always_ff @(posedge core_clk) begin
    if (srst || (ce && rstExc)) begin
      vtb_q      <= VTB_RESET;
      regRdata_q <= '0;
    end else if (ce) begin
      if (regWr && regAddr == REG_VTB) begin
        vtb_q <= regWdata;
      end
      regRdata_q <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdata = regRdata_q;
  assign pcOut    = pc_q;
  assign spOut    = sp_q;
  assign srOut    = sr_q;
  assign halted   = halt_q;

endmodule

`default_nettype wire

// >>> core/eprf_pkg.sv
package eprf_pkg;

  // ------
  // exception kinds, highest priority first
  // ------
  localparam int unsigned KINDS      = 7;
  localparam logic [2:0]  K_ADDR     = 3'h0;
  localparam logic [2:0]  K_BUS      = 3'h1;
  localparam logic [2:0]  K_G2       = 3'h2;
  localparam logic [2:0]  K_G3       = 3'h3;
  localparam logic [2:0]  K_TRACE    = 3'h4;
  localparam logic [2:0]  K_BKPT     = 3'h5;
  localparam logic [2:0]  K_IRQ      = 3'h6;
  localparam logic [2:0]  K_NONE     = 3'h7;
  localparam logic [2:0]  K_FIRST_G4 = 3'h4;

  // ------
  // vectors, reset values, frame layout
  // ------
  localparam logic [7:0]  VEC_BUS        = 8'h02;
  localparam logic [7:0]  VEC_ADDR       = 8'h03;
  localparam logic [7:0]  VEC_TRACE      = 8'h09;
  localparam logic [7:0]  VEC_HWBKPT     = 8'h0C;
  localparam logic [31:0] RST_ISP_ADDR   = 32'h0000_0000;
  localparam logic [31:0] RST_PC_ADDR    = 32'h0000_0004;
  localparam logic [31:0] VTB_RESET      = 32'h0000_0000;
  localparam logic [2:0]  IPM_RESET      = 3'h7;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam int unsigned VEC_SHIFT      = 2;
  localparam logic [3:0]  FMT_NORMAL     = 4'h0;
  localparam logic [3:0]  FMT_FAULT      = 4'hC;
  localparam logic [2:0]  FRAME_SSW      = 3'h0;
  localparam logic [2:0]  FRAME_FADDR    = 3'h1;
  localparam logic [2:0]  FRAME_IPTR     = 3'h2;
  localparam logic [2:0]  FRAME_VECW     = 3'h3;
  localparam logic [2:0]  FRAME_PC       = 3'h4;
  localparam logic [2:0]  FRAME_SR       = 3'h5;
  localparam logic [15:0] RST_OUT_CYCLES = 16'h0200;

  // ------
  // register port offsets
  // ------
  localparam logic [3:0] REG_VTB    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SR     = 4'h8;

  // ------
  // carriers
  // ------
  typedef struct packed {
    logic       traceHi;
    logic       traceLo;
    logic       supervisor;
    logic [1:0] rsv;
    logic [2:0] ipm;
    logic [7:0] ccr;
  } eprf_sr_t;

  typedef struct packed {
    logic [7:0] rsv;
    logic [1:0] cyc;
    logic       wr;
    logic [1:0] size;
    logic [2:0] fc;
  } eprf_ssw_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic        wr;
    logic [1:0]  cyc;
    logic [2:0]  fc;
    logic        prefetch;
    logic        released;
  } eprf_access_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } eprf_req_t;

endpackage

// >>> bench/eprf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module eprf_mem_model (
  // clock
  input  wire logic        core_clk,
  // access from the unit
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic        errOn,
  // answer
  output logic [31:0]      memRdata,
  output logic             memAck,
  output logic             memErr
);
  // ----
  // far-side memory
  // ----
  logic [1:0] cnt_q  = 2'h0;
  logic       slow_q = 1'h0;
  initial begin
    memAck   = 1'h0;
    memErr   = 1'h0;
    memRdata = 32'h0;
  end
  // alternate prompt and slow answers; idle data flips so stale reads show
  always @(posedge core_clk) begin
    memAck <= 1'h0;
    memErr <= 1'h0;
    if (memReq && !memAck && cnt_q == (slow_q ? 2'h3 : 2'h0)) begin
      memAck   <= 1'h1;
      memErr   <= errOn;
      memRdata <= memAddr + 32'h0000_1000;
      cnt_q    <= 2'h0;
      slow_q   <= !slow_q;
    end else if (memReq && !memAck)
      cnt_q <= cnt_q + 2'h1;
    else
      memRdata <= ~memRdata;
  end
endmodule

`default_nettype wire

// >>> bench/eprf_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module eprf_unit_asserts
  import eprf_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // reset sources and output
  input wire logic        resetPin,
  input wire logic        resetModule,
  input wire logic        resetInsn,
  input wire logic        resetOut,
  // fault and control
  input wire logic        busFaultPin,
  input wire logic        stallExec,
  input wire logic        restoreEa,
  input wire logic        fetchGo,
  input wire eprf_sr_t    srOut,
  input wire logic        halted,
  // memory port
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic        memAck,
  input wire logic        memErr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----
  // reset steps
  // ----
  sequence s_spRead;
    memReq && !memWrite && memAddr == RST_ISP_ADDR && memAck && !memErr;
  endsequence
  sequence s_pcRead;
    memReq && !memWrite && memAddr == RST_PC_ADDR && memAck;
  endsequence
  a_reset_status: assert property (disable iff (1'h0)
    (srst || resetPin || resetModule) |=> srOut.supervisor && !srOut.traceHi
    && !srOut.traceLo && srOut.ipm == IPM_RESET && !halted)
    else $error("reset left wrong status");
  a_reset_first_read: assert property ($fell(srst) |-> memReq && !memWrite
    && memAddr == RST_ISP_ADDR) else $error("reset did not read sp first");
  a_reset_order: assert property (s_spRead |=> ##[0:20] s_pcRead ##[1:2] fetchGo)
    else $error("reset vector order broken");
  a_reset_no_push: assert property ($fell(srst) |-> !memWrite [*8])
    else $error("reset pushed context");
  // ----
  // faults, halt and reset output
  // ----
  a_halt_sticks: assert property (halted && !resetPin && !resetModule |=> halted)
    else $error("halt left without reset");
  a_reset_out_hold: assert property (resetInsn |=> resetOut [*8])
    else $error("reset output not held");
  a_fault_stall: assert property (busFaultPin && !stallExec && !halted |=> stallExec)
    else $error("bus fault not taken");
  a_restore_push: assert property (restoreEa |-> ##[0:4] (memReq && memWrite))
    else $error("no push after restore");
endmodule

bind eprf_unit eprf_unit_asserts i_eprf_unit_asserts (
  .core_clk(core_clk), .srst(srst), .resetPin(resetPin), .resetModule(resetModule),
  .resetInsn(resetInsn), .resetOut(resetOut), .busFaultPin(busFaultPin),
  .stallExec(stallExec), .restoreEa(restoreEa), .fetchGo(fetchGo), .srOut(srOut),
  .halted(halted), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
  .memAck(memAck), .memErr(memErr)
);

`default_nettype wire

// >>> bench/test_exception_priority_reset_fault.sv
`timescale 1ns/1ps
`default_nettype none

module test_exception_priority_reset_fault;
  import eprf_pkg::*;
  // ----
  // rows: source bits (pin, module, watchdog, odd, trace, trap), vector, pushes
  // ----
  localparam logic [31:0] VTB = 32'h0000_0400;
  localparam logic [5:0] SRC [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h09, 6'h10, 6'h20};
  localparam logic [7:0] VEC [7] = '{VEC_BUS, VEC_BUS, VEC_BUS, VEC_ADDR, VEC_ADDR,
                                     VEC_TRACE, 8'h20};
  localparam int NW [7] = '{6, 6, 6, 6, 6, 3, 3};
  logic        core_clk  = 1'h0;
  logic        srst      = 1'h1;
  logic        errOn     = 1'h0;
  logic        resetInsn = 1'h0;
  logic [1:0]  rstSrc    = 2'h0;
  logic [9:0]  ex        = 10'h003; // ce, boundary, then core strobes
  logic [5:0]  src       = 6'h00;
  logic [3:0]  regAddr   = 4'h0;
  logic [31:0] regWdata  = 32'h0;
  logic        regWr     = 1'h0;
  logic        regRd     = 1'h0;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire logic        resetOut, stallExec, restoreEa, fetchGo, halted;
  wire logic        memReq, memWrite, memAck, memErr;
  wire logic [31:0] pcOut, spOut, memAddr, memRdata, regRdata;
  wire eprf_sr_t    srOut;

  eprf_unit i_eprf_unit (
    .core_clk(core_clk), .srst(srst), .ce(ex[0]), .resetPin(rstSrc[0]),
    .resetModule(rstSrc[1]), .resetInsn(resetInsn), .resetOut(resetOut),
    .busFaultPin(src[0]), .busFaultModule(src[1]), .busFaultWatchdog(src[2]),
    .accOdd(src[3]), .accInfo({32'h0000_3003, 10'h014}), .prefetchUsed(ex[2]),
    .prefetchFlush(ex[3]), .insnBoundary(ex[1]), .operandAccess(ex[4]),
    .rteStackRead(ex[5]), .branchOdd(ex[6]), .branchTarget(32'h0), .branchPc(32'h0),
    .curPc(32'h0000_2000), .group2Req({src[5], 8'h20}), .group3Req({ex[8], 8'h04}),
    .traceReq(src[4]), .hwBkptReq(ex[7]), .irqReq({ex[9], 8'h40}), .irqLevel(3'h0),
    .stallExec(stallExec), .restoreEa(restoreEa), .fetchGo(fetchGo), .pcOut(pcOut),
    .spOut(spOut), .srOut(srOut), .halted(halted), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(), .memRdata(memRdata),
    .memAck(memAck), .memErr(memErr), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata)
  );
  eprf_mem_model i_eprf_mem_model (
    .core_clk(core_clk), .memReq(memReq), .memAddr(memAddr), .errOn(errOn),
    .memRdata(memRdata), .memAck(memAck), .memErr(memErr)
  );

  // clock and hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk) begin regAddr <= a; regWdata <= v; regWr <= 1'h1; end
    @(posedge core_clk) regWr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk) begin regAddr <= a; regRd <= 1'h1; end
    @(posedge core_clk) regRd <= 1'h0;
    @(negedge core_clk) v = regRdata;
  endtask
  task automatic waitOn(input logic h);
    int t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (!(h ? halted : fetchGo) && t < 400);
  endtask
  task automatic runRow(input logic [5:0] s, input logic [7:0] v, input int nw);
    int n = 0;
    int t = 0;
    @(posedge core_clk) src <= s;
    @(posedge core_clk) src <= 6'h00;
    do begin
      @(negedge core_clk);
      t++;
      if (memReq && memWrite && memAck) n++;
    end while (!(memReq && !memWrite && memAck) && t < 300);
    check(memAddr, VTB + {22'h0, v, 2'h0});
    check(32'(n), 32'(nw));
    waitOn(1'h0);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'h0;
    waitOn(1'h0);
    check(pcOut, RST_PC_ADDR + 32'h0000_1000);
    check(spOut, RST_ISP_ADDR + 32'h0000_1000);
    check({26'h0, srOut.traceHi, srOut.traceLo, srOut.supervisor, srOut.ipm},
          {29'h1, IPM_RESET});
    rd(REG_VTB, d);
    check(d, VTB_RESET);
    wr(REG_VTB, VTB);
    rd(REG_VTB, d);
    check(d, VTB);
    rd(4'hC, d);
    check(d, 32'h0);
    for (int i = 0; i < 7; i++)
      runRow(SRC[i], VEC[i], NW[i]);
    // reset instruction: output pulse only, no register touched
    d = pcOut;
    @(posedge core_clk) resetInsn <= 1'h1;
    @(posedge core_clk) resetInsn <= 1'h0;
    @(negedge core_clk);
    check({31'h0, resetOut}, 32'h1);
    repeat (RST_OUT_CYCLES + 16'h4) @(negedge core_clk);
    check({31'h0, resetOut}, 32'h0);
    check(pcOut, d);
    // fault in fault stacking, then in reset; restart by pin, then module
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk) begin errOn <= 1'h1; src <= 6'(k == 0); rstSrc <= 2'(k); end
      @(posedge core_clk) begin src <= 6'h00; rstSrc <= 2'h0; end
      waitOn(1'h1);
      check({31'h0, halted}, 32'h1);
      @(posedge core_clk) begin errOn <= 1'h0; rstSrc <= 2'(k + 1); end
      @(posedge core_clk) rstSrc <= 2'h0;
      waitOn(1'h0);
      check({31'h0, halted}, 32'h0);
      check(spOut, RST_ISP_ADDR + 32'h0000_1000);
    end
    results();
  end
endmodule

`default_nettype wire
